// ===== core/afs_supervisor.sv
// actuator fault supervisor: bridge drive, monitoring and fault reaction
// Contract
// - power-up holds all four solenoid drives in their closed state.
// - bridge: two upper drives normally closed, two lower normally open.
// - setpoint outside 15%..85% of supply is an error.
// - floating setpoint means neutral demand, not an out-of-range error.
// - open or shorted transducer wire is an error.
// - overshoot beyond 12% (orifice 25%) or opposite side is an error.
// - neutral demand: spool outside +-0.5 mm of neutral is an error.
// - same side but nearer neutral counts as in control.
// - six-pin float: entry and exit each timed against own timeout.
// - active reaction starts after 500 ms of error, orifice 750 ms.
// - active reaction disables bridge, raises error output and lamp.
// - active fault latches until power cycle.
// - passive reaction starts after 250 ms of error, orifice 750 ms.
// - passive reaction keeps bridge running, raises error and lamp.
// - direction indicators both low while a reaction is active.
// - passive indication holds at least 100 ms, clears with error.
// - closed loop drives solenoids from setpoint minus position.
// - pwm variant takes setpoint from pwm duty only.
// - supply over 36 V, under 8.5 V or clock fail disables drives.
`include "afs_consts.svh"
`default_nettype none
module afs_supervisor #(
	parameter int unsigned QUAL_ACT_CYC = `AFS_T_ACT_MS * `AFS_CLK_KHZ,
	parameter int unsigned QUAL_PAS_CYC = `AFS_T_PAS_MS * `AFS_CLK_KHZ,
	parameter int unsigned QUAL_ORI_CYC = `AFS_T_ORI_MS * `AFS_CLK_KHZ,
	parameter int unsigned HOLD_CYC     = `AFS_T_HOLD_MS * `AFS_CLK_KHZ,
	parameter int unsigned FLT_IN_CYC   = `AFS_T_FLT_IN_MS * `AFS_CLK_KHZ,
	parameter int unsigned FLT_OUT_CYC  = `AFS_T_FLT_OUT_MS * `AFS_CLK_KHZ
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire afs_pkg::afs_straps_t straps,
	input  wire afs_pkg::afs_sense_t  sense,
	output afs_pkg::afs_bridge_t      bridge,
	output logic                      error_out,
	output logic                      lamp_red,
	output logic                      direction_indicator_a,
	output logic                      direction_indicator_b
);
	localparam logic [11:0] SP_LO =
		12'(`AFS_SP_FULL * `AFS_SP_LO_PCT / 100);
	localparam logic [11:0] SP_HI =
		12'(`AFS_SP_FULL * `AFS_SP_HI_PCT / 100);
	localparam logic signed [12:0] TOL_STD =
		13'(`AFS_SPAN * `AFS_TOL_STD_PCT / 100);
	localparam logic signed [12:0] TOL_ORI =
		13'(`AFS_SPAN * `AFS_TOL_ORI_PCT / 100);
	localparam logic signed [12:0] NB =
		13'(`AFS_SPAN * `AFS_NEUTRAL_UM / `AFS_STROKE_UM);
	localparam logic signed [12:0] DI_ON =
		13'(`AFS_SPAN * `AFS_DI_ON_UM / `AFS_STROKE_UM);
	localparam logic signed [12:0] DI_OFF =
		13'(`AFS_SPAN * `AFS_DI_OFF_UM / `AFS_STROKE_UM);
	localparam logic signed [13:0] DB = 14'(`AFS_CL_DEADBAND);
	localparam logic [9:0] SUP_MAX = 10'(`AFS_SUP_MAX_DV);
	localparam logic [9:0] SUP_MIN = 10'(`AFS_SUP_MIN_DV);

	afs_pkg::afs_core_t q_reg;
	afs_pkg::afs_core_t q_next;

	logic        [3:0]  tim_run;
	logic        [3:0]  tim_done;
	logic        [23:0] tim_lim [4];
	logic        [11:0] sp_sel;
	logic               sp_floating;
	logic               error_any;
	logic               mon_on;
	logic signed [12:0] dem_mag;
	logic signed [12:0] pos_mag;
	logic signed [12:0] tol;
	logic signed [13:0] cl_err;

	function automatic logic signed [12:0] mag(logic signed [12:0] v);
		return (v < 0) ? -v : v;
	endfunction

	// 0 qualify, 1 passive hold, 2 float entry, 3 float exit
	generate
		for (genvar i = 0; i < 4; i++) begin : g_tim
			afs_timer u_tim (
				.clk   (clk),
				.rst   (rst),
				.run   (tim_run[i]),
				.limit (tim_lim[i]),
				.done  (tim_done[i])
			);
		end
	endgenerate

	assign sp_sel      = q_reg.straps.pwm ? q_reg.pwm_code : sense.sp_code;
	assign sp_floating = !q_reg.straps.pwm && sense.sp_float;
	assign error_any   = q_reg.sp_err | q_reg.lvdt_err | q_reg.pos_err
		| q_reg.flt_err;
	assign mon_on      = q_reg.straps.mode != afs_pkg::AFS_MODE_NONE;
	assign dem_mag     = mag(q_reg.demand);
	assign pos_mag     = mag(q_reg.pos);
	assign tol         = q_reg.straps.orifice ? TOL_ORI : TOL_STD;
	assign cl_err      = 14'(q_reg.demand) - 14'(q_reg.pos);

	assign tim_run[0] = error_any && mon_on && q_reg.st == afs_pkg::AFS_ST_RUN;
	assign tim_run[1] = q_reg.passive_fault;
	assign tim_run[2] = q_reg.straps.float6 && sense.float_cmd
		&& !sense.float_active;
	assign tim_run[3] = q_reg.straps.float6 && !sense.float_cmd
		&& sense.float_active;
	assign tim_lim[0] = q_reg.straps.orifice ? 24'(QUAL_ORI_CYC) :
		(q_reg.straps.mode == afs_pkg::AFS_MODE_ACTIVE) ?
		24'(QUAL_ACT_CYC) : 24'(QUAL_PAS_CYC);
	assign tim_lim[1] = 24'(HOLD_CYC);
	assign tim_lim[2] = 24'(FLT_IN_CYC);
	assign tim_lim[3] = 24'(FLT_OUT_CYC);

	always_comb begin
		q_next = q_reg;
		// straps are caught in the first cycle after reset
		if (q_reg.st == afs_pkg::AFS_ST_INIT) begin
			q_next.straps = straps;
		end
		// pwm duty: high samples counted over a fixed window
		q_next.pwm_win = q_reg.pwm_win + 12'h1;
		if (q_reg.pwm_win == `AFS_PWM_WIN_MAX) begin
			q_next.pwm_code = (q_reg.pwm_hi >= `AFS_PWM_SAT) ? 12'hFFF :
				q_reg.pwm_hi[11:0];
			q_next.pwm_hi = 13'(sense.pwm_in);
		end else begin
			q_next.pwm_hi = q_reg.pwm_hi + 13'(sense.pwm_in);
		end
		q_next.sp_err = !sp_floating
			&& (sp_sel < SP_LO || sp_sel > SP_HI);
		q_next.demand = sp_floating ? 13'h0000 :
			13'({1'b0, sp_sel}) - `AFS_SP_MID;
		q_next.pos = 13'(sense.pos);
		q_next.lvdt_err = |{sense.lvdt_open, sense.lvdt_short};
		if (q_reg.power_bad) begin
			q_next.pos_err = 1'b0;
		end else if (q_reg.demand == 13'h0000) begin
			q_next.pos_err = pos_mag > NB;
		end else if ((q_reg.demand > 0) != (q_reg.pos > 0)) begin
			q_next.pos_err = pos_mag > NB;
		end else begin
			q_next.pos_err = pos_mag > dem_mag + tol;
		end
		q_next.flt_err = tim_done[2] | tim_done[3];
		q_next.power_bad = sense.supply_dv > SUP_MAX
			|| sense.supply_dv < SUP_MIN || sense.clk_fail;
		q_next.fault_latched = q_reg.fault_latched
			|| (q_reg.straps.mode == afs_pkg::AFS_MODE_ACTIVE
			&& tim_done[0]);
		q_next.passive_fault = (q_reg.passive_fault
			&& !(tim_done[1] && !error_any))
			|| (q_reg.straps.mode == afs_pkg::AFS_MODE_PASSIVE
			&& tim_done[0]);
		q_next.err_age = !tim_run[0] ? 24'h0 :
			(&q_reg.err_age) ? q_reg.err_age : q_reg.err_age + 24'h1;
		q_next.hold_age = !q_reg.passive_fault ? 24'h0 :
			(&q_reg.hold_age) ? q_reg.hold_age : q_reg.hold_age + 24'h1;
		case (q_reg.st)
			afs_pkg::AFS_ST_INIT: begin
				q_next.st = afs_pkg::AFS_ST_RUN;
				q_next.bridge.upper = 2'h0;
				q_next.bridge.lower = q_next.power_bad ? 2'h0 :
					`AFS_LOWER_CLOSED;
			end
			afs_pkg::AFS_ST_RUN: begin
				if (q_next.fault_latched || q_next.power_bad) begin
					q_next.bridge = '0;
				end else if (cl_err > DB) begin
					q_next.bridge.upper = 2'h1;
					q_next.bridge.lower = 2'h1;
				end else if (cl_err < -DB) begin
					q_next.bridge.upper = 2'h2;
					q_next.bridge.lower = 2'h2;
				end else begin
					q_next.bridge.upper = 2'h0;
					q_next.bridge.lower = `AFS_LOWER_CLOSED;
				end
			end
			default: begin
				q_next.st = afs_pkg::AFS_ST_INIT;
			end
		endcase
		q_next.error_out = q_next.fault_latched
			|| q_next.passive_fault;
		q_next.a_low = (q_reg.pos > DI_ON) ? 1'b1 :
			(q_reg.pos < DI_OFF) ? 1'b0 : q_reg.a_low;
		q_next.b_low = (q_reg.pos < -DI_ON) ? 1'b1 :
			(q_reg.pos > -DI_OFF) ? 1'b0 : q_reg.b_low;
		q_next.di_a = q_reg.straps.di && !q_next.a_low
			&& !q_next.error_out;
		q_next.di_b = q_reg.straps.di && !q_next.b_low
			&& !q_next.error_out;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q_reg <= '0;
			q_reg.bridge.lower <= `AFS_LOWER_CLOSED;
		end else begin
			q_reg <= q_next;
		end
	end

	assign bridge                = q_reg.bridge;
	assign error_out             = q_reg.error_out;
	assign lamp_red              = q_reg.error_out;
	assign direction_indicator_a = q_reg.di_a;
	assign direction_indicator_b = q_reg.di_b;

	property p_init_closed;
		@(posedge clk) disable iff (rst)
		q_reg.st == afs_pkg::AFS_ST_INIT |->
			bridge.upper == 2'h0 && bridge.lower == 2'h3;
	endproperty
	a_init_closed: assert property (p_init_closed)
		else $error("bridge not closed at power-up");

	property p_no_shoot;
		@(posedge clk) disable iff (rst)
		(bridge.upper & ~bridge.lower) == 2'h0;
	endproperty
	a_no_shoot: assert property (p_no_shoot)
		else $error("upper drive open while lower of same side open");

	property p_sp_range;
		@(posedge clk) disable iff (rst)
		(!q_reg.straps.pwm && !sense.sp_float
			&& (sense.sp_code < SP_LO || sense.sp_code > SP_HI))
			|=> q_reg.sp_err;
	endproperty
	a_sp_range: assert property (p_sp_range)
		else $error("setpoint out of window not flagged");

	property p_float_neutral;
		@(posedge clk) disable iff (rst)
		(!q_reg.straps.pwm && sense.sp_float)
			|=> !q_reg.sp_err && q_reg.demand == 13'h0000;
	endproperty
	a_float_neutral: assert property (p_float_neutral)
		else $error("floating setpoint not taken as neutral");

	sequence s_wire_bad;
		|{sense.lvdt_open, sense.lvdt_short};
	endsequence
	property p_lvdt;
		@(posedge clk) disable iff (rst)
		s_wire_bad |=> q_reg.lvdt_err;
	endproperty
	a_lvdt: assert property (p_lvdt)
		else $error("transducer wire fault not flagged");

	property p_opposite;
		@(posedge clk) disable iff (rst)
		(!q_reg.power_bad && q_reg.demand > 0 && q_reg.pos < -NB)
			|=> q_reg.pos_err;
	endproperty
	a_opposite: assert property (p_opposite)
		else $error("spool on opposite side not flagged");

	property p_overshoot;
		@(posedge clk) disable iff (rst)
		(!q_reg.power_bad && q_reg.demand > 0
			&& q_reg.pos > q_reg.demand + tol) |=> q_reg.pos_err;
	endproperty
	a_overshoot: assert property (p_overshoot)
		else $error("spool overshoot not flagged");

	property p_neutral_band;
		@(posedge clk) disable iff (rst)
		(!q_reg.power_bad && q_reg.demand == 13'h0000)
			|=> q_reg.pos_err == ($past(pos_mag) > NB);
	endproperty
	a_neutral_band: assert property (p_neutral_band)
		else $error("neutral band check wrong");

	property p_in_control;
		@(posedge clk) disable iff (rst)
		(q_reg.demand > 0 && q_reg.pos > 0 && q_reg.pos <= q_reg.demand)
			|=> !q_reg.pos_err;
	endproperty
	a_in_control: assert property (p_in_control)
		else $error("spool nearer neutral flagged as error");

	property p_float_time;
		@(posedge clk) disable iff (rst)
		(tim_done[2] || tim_done[3]) |=> q_reg.flt_err;
	endproperty
	a_float_time: assert property (p_float_time)
		else $error("float timeout not flagged");

	property p_act_delay;
		@(posedge clk) disable iff (rst)
		$rose(q_reg.fault_latched) |->
			$past(q_reg.err_age) == $past(tim_lim[0]);
	endproperty
	a_act_delay: assert property (p_act_delay)
		else $error("active reaction at wrong error age");

	property p_act_react;
		@(posedge clk) disable iff (rst)
		q_reg.fault_latched |-> bridge == '0 && error_out && lamp_red;
	endproperty
	a_act_react: assert property (p_act_react)
		else $error("active reaction incomplete");

	property p_latch;
		@(posedge clk) disable iff (rst)
		q_reg.fault_latched |=> q_reg.fault_latched [*8];
	endproperty
	a_latch: assert property (p_latch)
		else $error("active fault released without power cycle");

	property p_pas_delay;
		@(posedge clk) disable iff (rst)
		($rose(q_reg.passive_fault) && !q_reg.fault_latched) |->
			$past(q_reg.err_age) == $past(tim_lim[0]);
	endproperty
	a_pas_delay: assert property (p_pas_delay)
		else $error("passive reaction at wrong error age");

	property p_pas_run;
		@(posedge clk) disable iff (rst)
		(q_reg.passive_fault && !q_reg.fault_latched && !q_reg.power_bad
			&& q_reg.st == afs_pkg::AFS_ST_RUN)
			|-> bridge.lower != 2'h0 && error_out;
	endproperty
	a_pas_run: assert property (p_pas_run)
		else $error("passive reaction stopped the bridge");

	property p_di_low;
		@(posedge clk) disable iff (rst)
		error_out |-> !direction_indicator_a && !direction_indicator_b;
	endproperty
	a_di_low: assert property (p_di_low)
		else $error("direction indicator high during fault");

	property p_pas_hold;
		@(posedge clk) disable iff (rst)
		$fell(q_reg.passive_fault) |->
			$past(q_reg.hold_age) >= 24'(HOLD_CYC) && !$past(error_any);
	endproperty
	a_pas_hold: assert property (p_pas_hold)
		else $error("passive indication cleared early");

	property p_loop;
		@(posedge clk) disable iff (rst)
		(q_reg.st == afs_pkg::AFS_ST_RUN && !q_next.fault_latched
			&& !q_next.power_bad && cl_err > DB)
			|=> bridge.upper == 2'h1 && bridge.lower == 2'h1;
	endproperty
	a_loop: assert property (p_loop)
		else $error("closed loop did not drive toward demand");

	property p_pwm_only;
		@(posedge clk) disable iff (rst)
		(q_reg.straps.pwm && q_reg.pwm_code < SP_LO) |=> q_reg.sp_err;
	endproperty
	a_pwm_only: assert property (p_pwm_only)
		else $error("pwm setpoint not evaluated");

	sequence s_supply_bad;
		sense.supply_dv > SUP_MAX || sense.supply_dv < SUP_MIN
			|| sense.clk_fail;
	endsequence
	property p_supply;
		@(posedge clk) disable iff (rst)
		s_supply_bad |=> q_reg.power_bad && bridge == '0;
	endproperty
	a_supply: assert property (p_supply)
		else $error("drives not disabled on supply fault");
endmodule // afs_supervisor
`default_nettype wire

// ===== include/afs_consts.svh
// constants of the actuator fault supervisor
`ifndef AFS_CONSTS_SVH
`define AFS_CONSTS_SVH
`define AFS_CLK_KHZ        10000
`define AFS_TIM_W          24
`define AFS_SP_FULL        4096
`define AFS_SP_MID         13'h0800
`define AFS_SP_LO_PCT      15
`define AFS_SP_HI_PCT      85
`define AFS_SPAN           ((`AFS_SP_FULL * (`AFS_SP_HI_PCT - 50)) / 100)
`define AFS_STROKE_UM      7000
`define AFS_TOL_STD_PCT    12
`define AFS_TOL_ORI_PCT    25
`define AFS_NEUTRAL_UM     500
`define AFS_DI_ON_UM       800
`define AFS_DI_OFF_UM      400
`define AFS_CL_DEADBAND    8
`define AFS_SUP_MAX_DV     360
`define AFS_SUP_MIN_DV     85
`define AFS_PWM_WIN_MAX    12'hFFF
`define AFS_PWM_SAT        13'h0FFF
`define AFS_LOWER_CLOSED   2'h3
`define AFS_T_ACT_MS       500
`define AFS_T_PAS_MS       250
`define AFS_T_ORI_MS       750
`define AFS_T_HOLD_MS      100
`define AFS_T_FLT_IN_MS    500
`define AFS_T_FLT_OUT_MS   750
`endif

// ===== include/afs_pkg.sv
// types shared by the actuator fault supervisor
`default_nettype none
package afs_pkg;
	typedef enum logic {AFS_ST_INIT, AFS_ST_RUN} afs_state_t;
	typedef enum logic [1:0] {
		AFS_MODE_NONE, AFS_MODE_ACTIVE, AFS_MODE_PASSIVE
	} afs_mode_t;
	typedef struct packed {
		afs_mode_t mode;
		logic      orifice;
		logic      pwm;
		logic      float6;
		logic      di;
	} afs_straps_t;
	typedef struct packed {
		logic        [11:0] sp_code;
		logic               sp_float;
		logic               pwm_in;
		logic signed [11:0] pos;
		logic        [1:0]  lvdt_open;
		logic        [1:0]  lvdt_short;
		logic               float_cmd;
		logic               float_active;
		logic        [9:0]  supply_dv;
		logic               clk_fail;
	} afs_sense_t;
	typedef struct packed {
		logic [1:0] upper;
		logic [1:0] lower;
	} afs_bridge_t;
	typedef struct packed {
		logic [23:0] cnt;
		logic        done;
	} afs_tim_t;
	typedef struct packed {
		afs_state_t         st;
		afs_straps_t        straps;
		logic        [11:0] pwm_win;
		logic        [12:0] pwm_hi;
		logic        [11:0] pwm_code;
		logic signed [12:0] demand;
		logic signed [12:0] pos;
		logic               sp_err;
		logic               lvdt_err;
		logic               pos_err;
		logic               flt_err;
		logic               power_bad;
		logic               fault_latched;
		logic               passive_fault;
		logic               a_low;
		logic               b_low;
		afs_bridge_t        bridge;
		logic               error_out;
		logic               di_a;
		logic               di_b;
		logic        [23:0] err_age;
		logic        [23:0] hold_age;
	} afs_core_t;
endpackage
`default_nettype wire

// ===== core/afs_timer.sv
// qualification timer: counts uninterrupted run cycles up to a limit
`include "afs_consts.svh"
`default_nettype none
module afs_timer (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   run,
	input  wire logic [`AFS_TIM_W-1:0]  limit,
	output logic                        done
);
	afs_pkg::afs_tim_t q_reg;
	afs_pkg::afs_tim_t q_next;

	always_comb begin
		q_next = q_reg;
		if (!run) begin
			q_next.cnt = '0;
		end else if (q_reg.cnt < limit) begin
			q_next.cnt = q_reg.cnt + 24'h1;
		end
		q_next.done = run && (q_next.cnt >= limit);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign done = q_reg.done;

	property p_restart;
		@(posedge clk) disable iff (rst)
		!run |=> (q_reg.cnt == 24'h0) && !done;
	endproperty
	a_restart: assert property (p_restart)
		else $error("timer did not restart after run dropped");
endmodule // afs_timer
`default_nettype wire

// ===== tb/afs_ctrl_model.sv
// machine controller model: drives the setpoint pin and reads the error pin
`default_nettype none
module afs_ctrl_model (
	input  wire logic        clk,
	input  wire logic        error_out,
	output logic      [11:0] sp_code,
	output logic             sp_float
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] code_reg;
	logic        float_reg;
	logic [11:0] pat_reg;
	logic        err_seen;
	initial begin
		code_reg  = 12'h800;
		float_reg = 1'b0;
		pat_reg   = 12'hA5A;
		err_seen  = 1'b0;
	end
	// a released pin holds no value: the level wanders every cycle
	always @(negedge clk) begin
		pat_reg <= ~pat_reg;
	end
	always @(posedge clk) begin
		err_seen <= error_out;
	end
	assign sp_code  = float_reg ? pat_reg : code_reg;
	assign sp_float = float_reg;
	task drive_sp(input logic [11:0] code);
		code_reg  = code;
		float_reg = 1'b0;
	endtask
	task release_pin();
		float_reg = 1'b1;
	endtask
endmodule // afs_ctrl_model
`default_nettype wire

// ===== tb/tb_afs_supervisor.sv
// self-checking testbench of the actuator fault supervisor
`default_nettype none
module tb_afs_supervisor;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int QA = 20, QP = 10, QO = 30, HOLD = 8, FIN = 12, FOUT = 16;
	localparam afs_pkg::afs_bridge_t BR_HOLD = '{2'h0, 2'h3};
	localparam afs_pkg::afs_bridge_t BR_OFF  = '{2'h0, 2'h0};
	localparam afs_pkg::afs_bridge_t BR_FWD  = '{2'h1, 2'h1};
	localparam afs_pkg::afs_bridge_t BR_REV  = '{2'h2, 2'h2};
	logic                clk;
	logic                rst;
	afs_pkg::afs_straps_t straps;
	afs_pkg::afs_sense_t  sense;
	logic        [11:0]  sp_code;
	logic                sp_float;
	logic signed [11:0]  pos;
	logic        [1:0]   lv_open;
	logic        [1:0]   lv_short;
	logic                f_cmd;
	logic                f_act;
	logic        [9:0]   supply;
	logic                clk_fail;
	logic                pwm_in;
	logic                pwm_sel;
	logic                di_sel;
	afs_pkg::afs_bridge_t bridge;
	logic                error_out;
	logic                lamp_red;
	logic                di_a;
	logic                di_b;
	int                  err_total;
	int                  cmp_count;
	assign sense = {sp_code, sp_float, pwm_in, pos, lv_open, lv_short,
		f_cmd, f_act, supply, clk_fail};
	afs_ctrl_model afs_ctrl_model_inst (
		.clk(clk), .error_out(error_out), .sp_code(sp_code), .sp_float(sp_float)
	);
	afs_supervisor #(
		.QUAL_ACT_CYC(QA), .QUAL_PAS_CYC(QP), .QUAL_ORI_CYC(QO),
		.HOLD_CYC(HOLD), .FLT_IN_CYC(FIN), .FLT_OUT_CYC(FOUT)
	) afs_supervisor_inst (
		.clk(clk), .rst(rst), .straps(straps), .sense(sense), .bridge(bridge),
		.error_out(error_out), .lamp_red(lamp_red),
		.direction_indicator_a(di_a), .direction_indicator_b(di_b)
	);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task print_verdict();
		$display("summary: %0d compares, %0d mismatches", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task chk1(input logic got, input logic exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t ns: %s", $time, msg);
		end
	endtask
	task chk_br(input afs_pkg::afs_bridge_t got,
		input afs_pkg::afs_bridge_t exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t ns: %s bridge %h", $time, msg, got);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task do_reset(input afs_pkg::afs_mode_t m, input logic ori, input logic f6);
		@(negedge clk);
		rst = 1'b1;
		straps = '{m, ori, pwm_sel, f6, di_sel};
		pwm_in = 1'b0;
		pos = 12'h000;
		lv_open = 2'h0;
		lv_short = 2'h0;
		f_cmd = 1'b0;
		f_act = 1'b0;
		supply = 10'h0F0;
		clk_fail = 1'b0;
		afs_ctrl_model_inst.drive_sp(12'h800);
		cyc(2);
		chk_br(bridge, BR_HOLD, "reset state");
		rst = 1'b0;
		cyc(3);
	endtask
	// reaction must still be off after lo edges and on within hi-1 more
	task expect_rise(input int lo, input int hi);
		int n;
		cyc(lo);
		chk1(error_out, 1'b0, "reaction too early");
		n = 0;
		while (error_out !== 1'b1 && n < hi) begin
			cyc(1);
			n++;
		end
		if (n >= hi) begin
			err_total++;
			$display("[FAIL] %0t ns: reaction never came", $time);
			print_verdict();
		end
	endtask
	task hold_low(input int n, input string msg);
		cyc(n);
		chk1(error_out, 1'b0, msg);
	endtask
	task t_closed_loop();
		do_reset(afs_pkg::AFS_MODE_ACTIVE, 1'b0, 1'b0);
		chk1(di_a & di_b, 1'b1, "indicators high in neutral");
		afs_ctrl_model_inst.drive_sp(12'h8C8);
		cyc(4);
		chk_br(bridge, BR_FWD, "forward drive");
		pos = 12'sd100;
		hold_low(QA + 10, "nearer neutral flagged");
		pos = 12'sd0;
		afs_ctrl_model_inst.drive_sp(12'h738);
		cyc(4);
		chk_br(bridge, BR_REV, "reverse drive");
		$display("test closed_loop done");
	endtask
	task t_active();
		do_reset(afs_pkg::AFS_MODE_ACTIVE, 1'b0, 1'b0);
		afs_ctrl_model_inst.drive_sp(12'h1F4);
		expect_rise(QA + 1, 4);
		chk_br(bridge, BR_OFF, "bridge not released");
		chk1(lamp_red, 1'b1, "lamp not red");
		chk1(di_a | di_b, 1'b0, "indicators not low");
		afs_ctrl_model_inst.drive_sp(12'h800);
		cyc(QA + HOLD);
		chk1(error_out, 1'b1, "active fault not latched");
		chk_br(bridge, BR_OFF, "bridge came back");
		chk1(afs_ctrl_model_inst.err_seen, 1'b1, "no error seen");
		$display("test active done");
	endtask
	task t_passive();
		int n;
		do_reset(afs_pkg::AFS_MODE_PASSIVE, 1'b0, 1'b0);
		afs_ctrl_model_inst.drive_sp(12'hE10);
		expect_rise(QP + 1, 4);
		chk_br(bridge, BR_FWD, "bridge stopped");
		chk1(lamp_red, 1'b1, "lamp not red");
		chk1(di_a | di_b, 1'b0, "indicators not low");
		afs_ctrl_model_inst.drive_sp(12'h800);
		n = 1;
		while (error_out === 1'b1 && n < HOLD + 12) begin
			cyc(1);
			n++;
		end
		chk1(n >= HOLD, 1'b1, "indication too short");
		chk1(error_out, 1'b0, "indication did not clear");
		$display("test passive done");
	endtask
	task t_restart();
		do_reset(afs_pkg::AFS_MODE_PASSIVE, 1'b0, 1'b0);
		lv_open = 2'h1;
		cyc(QP - 2);
		lv_open = 2'h0;
		cyc(1);
		lv_open = 2'h2;
		expect_rise(QP + 1, 4);
		lv_open = 2'h0;
		$display("test restart done");
	endtask
	task t_position();
		logic        [11:0] sps [3];
		logic signed [11:0] poss [3];
		sps = '{12'h8C8, 12'h8C8, 12'h800};
		poss = '{12'sd411, -12'sd300, 12'sd150};
		for (int i = 0; i < 3; i++) begin
			do_reset(afs_pkg::AFS_MODE_PASSIVE, 1'b0, 1'b0);
			afs_ctrl_model_inst.drive_sp(sps[i]);
			pos = poss[i];
			expect_rise(QP + 2, 4);
		end
		$display("test position done");
	endtask
	task t_floating();
		do_reset(afs_pkg::AFS_MODE_PASSIVE, 1'b0, 1'b0);
		afs_ctrl_model_inst.release_pin();
		hold_low(QP + 10, "floating pin flagged");
		chk_br(bridge, BR_HOLD, "floating pin not neutral");
		afs_ctrl_model_inst.drive_sp(12'h800);
		$display("test floating done");
	endtask
	task t_orifice();
		do_reset(afs_pkg::AFS_MODE_ACTIVE, 1'b1, 1'b0);
		lv_short = 2'h1;
		expect_rise(QO + 1, 4);
		$display("test orifice done");
	endtask
	task t_float();
		do_reset(afs_pkg::AFS_MODE_ACTIVE, 1'b0, 1'b1);
		f_cmd = 1'b1;
		expect_rise(FIN + QA + 1, 8);
		do_reset(afs_pkg::AFS_MODE_ACTIVE, 1'b0, 1'b1);
		f_cmd = 1'b1;
		f_act = 1'b1;
		hold_low(4, "float entry flagged");
		f_cmd = 1'b0;
		expect_rise(FOUT + QA + 1, 8);
		$display("test float done");
	endtask
	task t_power();
		do_reset(afs_pkg::AFS_MODE_ACTIVE, 1'b0, 1'b0);
		afs_ctrl_model_inst.drive_sp(12'h8C8);
		for (int i = 0; i < 3; i++) begin
			supply = (i == 0) ? 10'h190 : (i == 1) ? 10'h050 : 10'h0F0;
			clk_fail = (i == 2);
			cyc(3);
			chk_br(bridge, BR_OFF, "drives not cut");
			supply = 10'h0F0;
			clk_fail = 1'b0;
			cyc(4);
			chk_br(bridge, BR_FWD, "drives not back");
		end
		hold_low(QA, "supply fault raised reaction");
		$display("test power done");
	endtask
	// pwm strap: valid voltage level ignored, half duty accepted
	task t_pwm();
		pwm_sel = 1'b1;
		di_sel = 1'b0;
		do_reset(afs_pkg::AFS_MODE_PASSIVE, 1'b0, 1'b0);
		pwm_sel = 1'b0;
		di_sel = 1'b1;
		chk1(di_a | di_b, 1'b0, "indicators without strap");
		expect_rise(QP - 1, 4);
		repeat (4100) begin
			pwm_in = ~pwm_in;
			cyc(1);
		end
		chk1(error_out, 1'b0, "pwm duty not taken");
		pwm_in = 1'b0;
		$display("test pwm done");
	endtask
	task t_none();
		do_reset(afs_pkg::AFS_MODE_NONE, 1'b0, 1'b0);
		afs_ctrl_model_inst.drive_sp(12'h1F4);
		hold_low(QA + 10, "reaction without monitoring");
		chk_br(bridge, BR_REV, "bridge stopped unmonitored");
		$display("test none done");
	endtask
	initial begin
		err_total = 0;
		cmp_count = 0;
		rst = 1'b1;
		straps = '{afs_pkg::AFS_MODE_NONE, 1'b0, 1'b0, 1'b0, 1'b0};
		pos = 12'h000;
		lv_open = 2'h0;
		lv_short = 2'h0;
		f_cmd = 1'b0;
		f_act = 1'b0;
		supply = 10'h0F0;
		clk_fail = 1'b0;
		pwm_in = 1'b0;
		pwm_sel = 1'b0;
		di_sel = 1'b1;
		t_closed_loop();
		t_active();
		t_passive();
		t_restart();
		t_position();
		t_floating();
		t_orifice();
		t_float();
		t_power();
		t_pwm();
		t_none();
		print_verdict();
	end
endmodule // tb_afs_supervisor
`default_nettype wire
